//--- bcr_pkg.sv
// Shared constants, types and state encodings for the board control register bank
package bcr_pkg;

    // ----------------------------------------
    // Register offsets on the board control bus
    // ----------------------------------------
    localparam logic [7:0] BCR_OFS_FLASH_ROUTE = 8'h07;
    localparam logic [7:0] BCR_OFS_MISC_OUTPUT = 8'h09;
    localparam logic [7:0] BCR_OFS_SWITCH_READ = 8'h0a;
    localparam logic [7:0] BCR_OFS_AMP_DISABLE = 8'h0b;

    // ----------------------------------------
    // Reset values and implemented bit masks
    // ----------------------------------------
    localparam logic [7:0] BCR_RST_FLASH_ROUTE = 8'h00;
    localparam logic [7:0] BCR_RST_MISC_OUTPUT = 8'h00;
    localparam logic [7:0] BCR_RST_AMP_DISABLE = 8'h00;
    localparam logic [7:0] BCR_MASK_FLASH_ROUTE = 8'h03;
    localparam logic [7:0] BCR_MASK_MISC_OUTPUT = 8'hf3;
    localparam logic [7:0] BCR_MASK_SWITCH_READ = 8'h0f;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BCR_FLASH_SEL_LSB = 0;
    localparam int BCR_RM1_LSB = 6;
    localparam int BCR_RM0_LSB = 4;
    localparam int BCR_CLKB_BIT = 1;
    localparam int BCR_COUPLE_BIT = 0;
    localparam int BCR_SWITCH_WIDTH = 4;

    // ----------------------------------------
    // Field encodings
    // ----------------------------------------
    localparam logic [1:0] BCR_ROUTE_BOOTPIN = 2'h0;
    localparam logic [1:0] BCR_ROUTE_FLASH0 = 2'h1;
    localparam logic [1:0] BCR_ROUTE_FLASH1 = 2'h2;
    localparam logic [1:0] BCR_ROUTE_NONE = 2'h3;
    localparam logic [1:0] BCR_RM_TRISTATE = 2'h0;
    localparam logic [1:0] BCR_RM_DRIVE_LOW = 2'h2;
    localparam logic [1:0] BCR_RM_DRIVE_HIGH = 2'h3;

    // ----------------------------------------
    // Register layouts
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] rearOff1;
        logic [1:0] rearOff0;
        logic [1:0] reserved;
        logic bpClockBDrvEn;
        logic cfgBusCouple;
    } bcr_misc_type;

    typedef struct packed {
        logic ampGroupDExtraOff;
        logic ampGroupDOff;
        logic ampGroupCExtraOff;
        logic ampGroupCOff;
        logic ampGroupBExtraOff;
        logic ampGroupBOff;
        logic ampGroupAExtraOff;
        logic ampGroupAOff;
    } bcr_amp_type;

    typedef enum logic [3:0] {
        BCR_IDLE, BCR_ADDR, BCR_ADDR_ACK, BCR_PTR, BCR_PTR_ACK,
        BCR_WDATA, BCR_WDATA_ACK, BCR_RDATA, BCR_RDATA_ACK
    } bcr_state_type;

endpackage

//--- bcr_sync.sv
// Two-stage synchroniser for pin-level inputs
`timescale 1ns/10ps
module bcr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_q;

    // First stage feeds only the second stage
    // Reset to each pin's idle level, so releasing reset shows no false edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1_q <= RESET_VALUE;
            syncOut <= RESET_VALUE;
        end else begin
            stage1_q <= asyncIn;
            syncOut <= stage1_q;
        end
    end
endmodule

//--- bcr_bank.sv
// Board control register bank behind an I2C slave on the board control bus
// Notes on behaviour
// - Two-bit flash route: boot pins, flash zero, flash one, or both disconnected.
// - Flash route field is read/write and resets to boot-pin routing.
// - Misc bits 7:6 drive rear-module turn-off one: tristate, low, high; reset tristate.
// - Misc bits 5:4 drive rear-module turn-off zero, same coding, reset tristate.
// - Misc bit 1 enables backplane clock B driver; read/write, resets to zero.
// - Misc bit 0 couples the FPGA onto the configuration bus; read/write.
// - Coupling bit resets to zero so the FPGA starts decoupled.
// - Switch register low nibble reads current switches, read-only, one means disabled.
// - Amp bit 0 disables paths 0-3, 5-7; bit 1 disables path 4.
// - Amp bit 2 disables paths 8, 9, 11-15; bit 3 disables path 10.
// - Amp bit 4 disables paths 17-21, 23; bit 5 disables paths 16, 22.
// - Amp bit 6 disables paths 24-27, 29-31; bit 7 disables path 28.
// - All amp disable bits are read/write and reset to zero.
// - Amp settings reach outputs only while a compatible rear module is signalled.
`timescale 1ns/10ps
module bcr_bank
    import bcr_pkg::*;
#(
    parameter logic [6:0] I2C_ADDR = 7'h2a
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    input wire logic [3:0] boardSwitchState,
    input wire logic fpgaBootSelectPins,
    input wire logic rearModuleCompat,
    output logic [1:0] flashRouteSel,
    output logic [1:0] flashLinkEn,
    output logic [1:0] rearModuleOffOut,
    output logic [1:0] rearModuleOffOeN,
    output logic bpClockBDrvEn,
    output logic cfgBusCouple,
    output logic [31:0] ampPathOff
);

    // ----------------------------------------
    // Input synchronisation
    // ----------------------------------------
    logic [7:0] syncBus;
    logic sclS;
    logic sdaS;
    logic [3:0] switchS;
    logic bootS;
    logic compatS;
    logic sclPrev_q;
    logic sdaPrev_q;

    bcr_sync #(.WIDTH(8), .RESET_VALUE({2'b11, 6'h00})) uSync (
        .clk(clk),
        .nrst(nrst),
        .asyncIn({sclIn, sdaIn, boardSwitchState, fpgaBootSelectPins, rearModuleCompat}),
        .syncOut(syncBus)
    );

    assign sclS = syncBus[7];
    assign sdaS = syncBus[6];
    assign switchS = syncBus[5:2];
    assign bootS = syncBus[1];
    assign compatS = syncBus[0];

    // Idle bus is high, so reset the history high to avoid a false start
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
        end
    end

    wire sclRise = sclS && !sclPrev_q;
    wire sclFall = !sclS && sclPrev_q;
    wire startSeen = sclS && sclPrev_q && sdaPrev_q && !sdaS;
    wire stopSeen = sclS && sclPrev_q && !sdaPrev_q && sdaS;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    function automatic logic [1:0] rearCode(input logic [1:0] code);
        // Returns {drive enable, level}; the reserved code is kept off the pin
        unique case (code)
            BCR_RM_DRIVE_LOW: rearCode = 2'h2;
            BCR_RM_DRIVE_HIGH: rearCode = 2'h3;
            default: rearCode = 2'h0;
        endcase
    endfunction

    function automatic logic [31:0] pathMap(input bcr_amp_type grp);
        logic [31:0] res;
        logic [7:0] g;
        logic extra;
        res = '0;
        g = grp;
        for (int i = 0; i < 32; i++) begin
            extra = (i == 4) || (i == 10) || (i == 16) || (i == 22) || (i == 28);
            res[i] = extra ? g[2 * (i / 8) + 1] : g[2 * (i / 8)];
        end
        pathMap = res;
    endfunction

    // ----------------------------------------
    // I2C slave state
    // ----------------------------------------
    bcr_state_type state_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic rw_q;
    logic nack_q;
    logic [1:0] flashRoute_q;
    bcr_misc_type misc_q;
    bcr_amp_type amp_q;

    wire byteDone = sclFall && (bitCnt_q == 4'h8);
    wire addrMatch = shift_q[7:1] == I2C_ADDR;
    wire wrEn = byteDone && (state_q == BCR_WDATA);
    wire rdLoad = sclFall && ((state_q == BCR_ADDR_ACK && rw_q)
        || (state_q == BCR_RDATA_ACK && !nack_q));
    wire wrFlash = wrEn && (ptr_q == BCR_OFS_FLASH_ROUTE);
    wire wrMisc = wrEn && (ptr_q == BCR_OFS_MISC_OUTPUT);
    wire wrAmp = wrEn && (ptr_q == BCR_OFS_AMP_DISABLE);
    wire ptrMapped = (ptr_q == BCR_OFS_FLASH_ROUTE) || (ptr_q == BCR_OFS_MISC_OUTPUT)
        || (ptr_q == BCR_OFS_SWITCH_READ) || (ptr_q == BCR_OFS_AMP_DISABLE);

    // Unmapped offsets read as zero; reserved bits are never stored
    wire [7:0] rdFlash = {6'h00, flashRoute_q} & BCR_MASK_FLASH_ROUTE;
    wire [7:0] rdMisc = misc_q & BCR_MASK_MISC_OUTPUT;
    wire [7:0] rdSwitch = {4'h0, switchS} & BCR_MASK_SWITCH_READ;
    wire [7:0] rdByte = (ptr_q == BCR_OFS_FLASH_ROUTE) ? rdFlash :
                        (ptr_q == BCR_OFS_MISC_OUTPUT) ? rdMisc :
                        (ptr_q == BCR_OFS_SWITCH_READ) ? rdSwitch :
                        (ptr_q == BCR_OFS_AMP_DISABLE) ? amp_q : 8'h00;

    // ----------------------------------------
    // Protocol engine
    // ----------------------------------------
    // Data is sampled on SCL rise and changed on SCL fall, so the
    // synchroniser delay stays well inside the low phase of the clock.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= BCR_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
            sdaOeN <= 1'b1;
        end else if (startSeen) begin
            state_q <= BCR_ADDR;
            bitCnt_q <= 4'h0;
            sdaOeN <= 1'b1;
        end else if (stopSeen) begin
            state_q <= BCR_IDLE;
            sdaOeN <= 1'b1;
        end else if (sclRise) begin
            shift_q <= {shift_q[6:0], sdaS};
            bitCnt_q <= bitCnt_q + 4'h1;
            if (state_q == BCR_RDATA_ACK) begin
                nack_q <= sdaS;
            end
        end else if (sclFall) begin
            unique case (state_q)
                BCR_IDLE: begin
                    sdaOeN <= 1'b1;
                end
                BCR_ADDR: begin
                    if (byteDone) begin
                        state_q <= addrMatch ? BCR_ADDR_ACK : BCR_IDLE;
                        rw_q <= shift_q[0];
                        sdaOeN <= !addrMatch;
                    end
                end
                BCR_ADDR_ACK: begin
                    bitCnt_q <= 4'h0;
                    if (rw_q) begin
                        state_q <= BCR_RDATA;
                        tx_q <= rdByte;
                        sdaOeN <= rdByte[7];
                    end else begin
                        state_q <= BCR_PTR;
                        sdaOeN <= 1'b1;
                    end
                end
                BCR_PTR: begin
                    if (byteDone) begin
                        state_q <= BCR_PTR_ACK;
                        ptr_q <= shift_q;
                        sdaOeN <= 1'b0;
                    end
                end
                BCR_PTR_ACK, BCR_WDATA_ACK: begin
                    state_q <= BCR_WDATA;
                    bitCnt_q <= 4'h0;
                    sdaOeN <= 1'b1;
                end
                BCR_WDATA: begin
                    if (byteDone) begin
                        state_q <= BCR_WDATA_ACK;
                        sdaOeN <= 1'b0;
                    end
                end
                BCR_RDATA: begin
                    if (byteDone) begin
                        state_q <= BCR_RDATA_ACK;
                        sdaOeN <= 1'b1;
                    end else begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        sdaOeN <= tx_q[6];
                    end
                end
                BCR_RDATA_ACK: begin
                    bitCnt_q <= 4'h0;
                    if (nack_q) begin
                        state_q <= BCR_IDLE;
                        sdaOeN <= 1'b1;
                    end else begin
                        state_q <= BCR_RDATA;
                        tx_q <= rdByte;
                        sdaOeN <= rdByte[7];
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    // Writes keep only the writable bits, so reserved bits stay zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flashRoute_q <= BCR_RST_FLASH_ROUTE[1:0];
            misc_q <= BCR_RST_MISC_OUTPUT;
            amp_q <= BCR_RST_AMP_DISABLE;
        end else begin
            if (wrFlash) begin
                flashRoute_q <= shift_q[BCR_FLASH_SEL_LSB +: 2];
            end
            if (wrMisc) begin
                misc_q <= shift_q & BCR_MASK_MISC_OUTPUT;
            end
            if (wrAmp) begin
                amp_q <= shift_q;
            end
        end
    end

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    wire [1:0] rear1 = rearCode(misc_q.rearOff1);
    wire [1:0] rear0 = rearCode(misc_q.rearOff0);
    wire [1:0] linkByRoute = (flashRoute_q == BCR_ROUTE_FLASH0) ? 2'h1 :
                             (flashRoute_q == BCR_ROUTE_FLASH1) ? 2'h2 :
                             (flashRoute_q == BCR_ROUTE_NONE) ? 2'h0 :
                             (bootS ? 2'h2 : 2'h1);
    // Amplifiers follow the register only with a compatible rear module
    wire [7:0] ampGated = compatS ? amp_q : 8'h00;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sdaOut <= 1'b0;
            flashRouteSel <= BCR_ROUTE_BOOTPIN;
            flashLinkEn <= 2'h0;
            rearModuleOffOut <= 2'h0;
            rearModuleOffOeN <= 2'h3;
            bpClockBDrvEn <= 1'b0;
            cfgBusCouple <= 1'b0;
            ampPathOff <= '0;
        end else begin
            sdaOut <= 1'b0;
            flashRouteSel <= flashRoute_q;
            flashLinkEn <= linkByRoute;
            rearModuleOffOut <= {rear1[0], rear0[0]};
            rearModuleOffOeN <= {!rear1[1], !rear0[1]};
            bpClockBDrvEn <= misc_q.bpClockBDrvEn;
            cfgBusCouple <= misc_q.cfgBusCouple;
            ampPathOff <= pathMap(bcr_amp_type'(ampGated));
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    flash_write_a: assert property (
        wrFlash |-> ##2 flashRouteSel == $past(shift_q[1:0], 2))
        else $error("flash route write not reflected");

    flash_link_a: assert property (
        flashRoute_q == BCR_ROUTE_NONE |=> flashLinkEn == 2'h0)
        else $error("flash links not disconnected");

    rear_one_low_a: assert property (
        misc_q.rearOff1 == BCR_RM_DRIVE_LOW |=> !rearModuleOffOeN[1] && !rearModuleOffOut[1])
        else $error("turn-off one not driven low");

    rear_zero_tri_a: assert property (
        misc_q.rearOff0 == BCR_RM_TRISTATE |=> rearModuleOffOeN[0])
        else $error("turn-off zero not tristate");

    clock_b_en_a: assert property (
        wrMisc |-> ##2 bpClockBDrvEn == $past(shift_q[BCR_CLKB_BIT], 2))
        else $error("clock B enable mismatch");

    bus_couple_a: assert property (
        wrMisc |-> ##2 cfgBusCouple == $past(shift_q[BCR_COUPLE_BIT], 2))
        else $error("configuration bus coupling mismatch");

    switch_read_a: assert property (
        rdLoad && ptr_q == BCR_OFS_SWITCH_READ |=> tx_q == {4'h0, $past(switchS)})
        else $error("switch readback wrong");

    amp_gate_a: assert property (
        !compatS |=> ampPathOff == 32'h0000_0000)
        else $error("amplifier disable leaked without rear module");

    amp_path_a: assert property (
        compatS && amp_q.ampGroupAExtraOff |=> ampPathOff[4])
        else $error("path 4 not disabled");

    reserved_zero_a: assert property (
        rdLoad && ptr_q == BCR_OFS_MISC_OUTPUT |=> tx_q[3:2] == 2'h0)
        else $error("reserved misc bits read nonzero");

    unmapped_write_a: assert property (
        wrEn && !ptrMapped |=> $stable(flashRoute_q) && $stable(misc_q) && $stable(amp_q))
        else $error("unmapped write changed a register");

endmodule

//--- bcr_host_model.sv
// I2C master model standing in for the board control host
`timescale 1ns/10ps
module bcr_host_model #(
    parameter int HALF = 8
) (
    input wire logic clk,
    input wire logic sdaLine,
    output logic sclOut,
    output logic sdaPullLow
);
    initial begin
        sclOut = 1'b1;
        sdaPullLow = 1'b0;
    end

    task automatic waitClk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // SDA moves only once SCL low has settled, so no false START or STOP is seen
    task automatic putBit(input logic v, output logic seen);
        sdaPullLow = ~v;
        waitClk(HALF);
        sclOut = 1'b1;
        waitClk(HALF);
        seen = sdaLine;
        sclOut = 1'b0;
        waitClk(4);
    endtask

    task automatic startCond();
        sdaPullLow = 1'b0;
        waitClk(HALF);
        sclOut = 1'b1;
        waitClk(HALF);
        sdaPullLow = 1'b1;
        waitClk(HALF);
        sclOut = 1'b0;
        waitClk(4);
    endtask

    task automatic stopCond();
        sdaPullLow = 1'b1;
        waitClk(HALF);
        sclOut = 1'b1;
        waitClk(HALF);
        sdaPullLow = 1'b0;
        waitClk(HALF);
    endtask

    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            putBit(b[i], s);
        end
        putBit(1'b1, s);
        ack = ~s;
    endtask

    task automatic regWrite(input logic [6:0] dev, input logic [7:0] ofs,
            input logic [7:0] data, output logic [2:0] acks);
        startCond();
        sendByte({dev, 1'b0}, acks[2]);
        sendByte(ofs, acks[1]);
        sendByte(data, acks[0]);
        stopCond();
    endtask

    task automatic regRead(input logic [6:0] dev, input logic [7:0] ofs,
            output logic [7:0] data, output logic [2:0] acks);
        logic s;
        startCond();
        sendByte({dev, 1'b0}, acks[2]);
        sendByte(ofs, acks[1]);
        startCond();
        sendByte({dev, 1'b1}, acks[0]);
        for (int i = 7; i >= 0; i--) begin
            putBit(1'b1, data[i]);
        end
        // Not-acknowledge: only one byte per read
        putBit(1'b1, s);
        stopCond();
    endtask
endmodule

//--- test_board_control_register_bank.sv
// Self-checking testbench for the board control register bank
`timescale 1ns/10ps
module test_board_control_register_bank;
    import bcr_pkg::*;

`define CHK(g, e, m) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        errors++; \
        $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e); \
    end \
end

    localparam logic [6:0] DEV = 7'h2a;
    localparam logic [31:0] AMP_MAP [8] = '{32'h000000ef, 32'h00000010, 32'h0000fb00,
        32'h00000400, 32'h00be0000, 32'h00410000, 32'hef000000, 32'h10000000};

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] boardSwitchState = 4'h0;
    logic fpgaBootSelectPins = 1'b0;
    logic rearModuleCompat = 1'b0;
    logic sclLine, hostLow, sdaLine, sdaOut, sdaOeN, bpClockBDrvEn, cfgBusCouple;
    logic [1:0] flashRouteSel, flashLinkEn, rearModuleOffOut, rearModuleOffOeN;
    logic [31:0] ampPathOff;
    int errors = 0;
    int total_checks = 0;

    // Open-drain data line with pull-up
    assign sdaLine = ~hostLow & (sdaOeN | sdaOut);

    always #2 clk = ~clk;

    bcr_bank #(.I2C_ADDR(DEV)) u_bcr_bank (
        .clk(clk), .nrst(nrst), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOeN(sdaOeN), .boardSwitchState(boardSwitchState),
        .fpgaBootSelectPins(fpgaBootSelectPins), .rearModuleCompat(rearModuleCompat),
        .flashRouteSel(flashRouteSel), .flashLinkEn(flashLinkEn),
        .rearModuleOffOut(rearModuleOffOut), .rearModuleOffOeN(rearModuleOffOeN),
        .bpClockBDrvEn(bpClockBDrvEn), .cfgBusCouple(cfgBusCouple), .ampPathOff(ampPathOff)
    );

    bcr_host_model u_bcr_host_model (
        .clk(clk), .sdaLine(sdaLine), .sclOut(sclLine), .sdaPullLow(hostLow)
    );

    task automatic summarize();
        if (errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [7:0] data);
        logic [2:0] a;
        u_bcr_host_model.regWrite(DEV, ofs, data, a);
        `CHK(a, 3'b111, "write ack")
    endtask

    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        logic [2:0] a;
        logic [7:0] d;
        u_bcr_host_model.regRead(DEV, ofs, d, a);
        `CHK(a, 3'b111, "read ack")
        `CHK(d, exp, "read data")
    endtask

    task automatic testReset();
        repeat (11) @(negedge clk);
        `CHK({flashRouteSel, cfgBusCouple, bpClockBDrvEn}, 4'h0, "reset ctl")
        `CHK({rearModuleOffOeN, sdaOeN, sdaOut, ampPathOff}, 36'he00000000, "reset out")
        @(negedge clk);
        nrst = 1'b1;
        repeat (5) @(negedge clk);
        rd(BCR_OFS_FLASH_ROUTE, 8'h00);
        rd(BCR_OFS_MISC_OUTPUT, 8'h00);
        rd(BCR_OFS_AMP_DISABLE, 8'h00);
    endtask

    task automatic testFlash();
        for (int c = 0; c < 4; c++) begin
            wr(BCR_OFS_FLASH_ROUTE, 8'hfc | 8'(c));
            for (int p = 0; p < 2; p++) begin
                fpgaBootSelectPins = p[0];
                repeat (6) @(negedge clk);
                `CHK(flashRouteSel, c[1:0], "route sel")
                `CHK(flashLinkEn, (c == 0) ? (p ? 2'b10 : 2'b01) :
                    (c == 1) ? 2'b01 : (c == 2) ? 2'b10 : 2'b00, "flash link")
            end
            rd(BCR_OFS_FLASH_ROUTE, 8'(c));
        end
    endtask

    task automatic testMisc();
        // Only legal turn-off codes are written
        logic [7:0] vals [4] = '{8'hbe, 8'hed, 8'h33, 8'hc0};
        for (int i = 0; i < 4; i++) begin
            wr(BCR_OFS_MISC_OUTPUT, vals[i]);
            repeat (4) @(negedge clk);
            `CHK(rearModuleOffOeN, {~vals[i][7], ~vals[i][5]}, "off enable")
            if (vals[i][7]) `CHK(rearModuleOffOut[1], vals[i][6], "off one")
            if (vals[i][5]) `CHK(rearModuleOffOut[0], vals[i][4], "off zero")
            `CHK(bpClockBDrvEn, vals[i][1], "clock b")
            `CHK(cfgBusCouple, vals[i][0], "couple")
            rd(BCR_OFS_MISC_OUTPUT, vals[i] & 8'hf3);
        end
    endtask

    task automatic testSwitch();
        boardSwitchState = 4'h5;
        repeat (6) @(negedge clk);
        rd(BCR_OFS_SWITCH_READ, 8'h05);
        boardSwitchState = 4'ha;
        wr(BCR_OFS_SWITCH_READ, 8'hff);
        rd(BCR_OFS_SWITCH_READ, 8'h0a);
    endtask

    task automatic testAmp();
        rearModuleCompat = 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr(BCR_OFS_AMP_DISABLE, 8'h01 << i);
            repeat (4) @(negedge clk);
            `CHK(ampPathOff, AMP_MAP[i], "amp map")
        end
        wr(BCR_OFS_AMP_DISABLE, 8'hff);
        rearModuleCompat = 1'b0;
        repeat (6) @(negedge clk);
        `CHK(ampPathOff, 32'h00000000, "amp no compat")
        rd(BCR_OFS_AMP_DISABLE, 8'hff);
        rearModuleCompat = 1'b1;
        repeat (6) @(negedge clk);
        `CHK(ampPathOff, 32'hffffffff, "amp compat")
    endtask

    task automatic testMap();
        logic [2:0] a;
        wr(8'h08, 8'h5a);
        rd(8'h08, 8'h00);
        wr(BCR_OFS_FLASH_ROUTE, 8'h01);
        u_bcr_host_model.regWrite(DEV ^ 7'h01, BCR_OFS_FLASH_ROUTE, 8'h03, a);
        `CHK(a, 3'b000, "foreign address")
        rd(BCR_OFS_FLASH_ROUTE, 8'h01);
    endtask

    // Whole run is about 25k cycles; the limit leaves ample margin
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        summarize();
    end

    initial begin
        testReset();
        testFlash();
        testMisc();
        testSwitch();
        testAmp();
        testMap();
        summarize();
    end
endmodule
